// File: inc/wimc_regs.vh
// constants for the wake-up and interrupt mode control block
`ifndef WIMC_REGS_VH
`define WIMC_REGS_VH
`define WIMC_MODE_W      2
`define WIMC_MODE_SLEEP  2'h0
`define WIMC_MODE_IDLE   2'h1
`define WIMC_MODE_GREEN  2'h2
`define WIMC_MODE_NORMAL 2'h3
`define WIMC_SRC_W       12
`define WIMC_SRC_EXT     0
`define WIMC_SRC_PORT    1
`define WIMC_SRC_CMP     2
`define WIMC_SRC_ADC     3
`define WIMC_SRC_SPI     4
`define WIMC_SRC_MTMR    5
`define WIMC_SRC_T1      6
`define WIMC_SRC_T2      7
`define WIMC_SRC_T3      8
`define WIMC_SRC_PWM     9
`define WIMC_SRC_UTX     10
`define WIMC_SRC_URX     11
`define WIMC_SRC_NONE    12'h000
`endif

// File: rtl/wimc_ctrl.v
// wake-up, interrupt dispatch and reset decision across the four power modes
`timescale 1ns/1ps
`include "wimc_regs.vh"
// How it works
// RL1: in sleep/idle, external pin event wakes only with ext_pin_wake_en set
// RL2: in sleep/idle, port 6 change wakes only with port_change_wake_en set
// RL3: in sleep/idle, comparator change wakes only with comparator_wake_en set
// RL4: in sleep/idle, adc done wakes only with adc_done_wake_en set
// RL5: adc busy in sleep, idle or green keeps main and sub clocks running
// RL6: timers and pwm period match wake from idle, never from sleep
// RL7: spi wakes from sleep only as slave receiving data
// RL8: uart transmit complete never wakes; interrupt only in green or normal
// RL9: uart receive full or error never wakes; interrupt only in green or normal
// RL10: in green/normal, events vector if interrupts enabled, else continue
// RL11: watchdog time-out or low voltage resets the device in every mode
// RL12: wake enables are latched when the sleep instruction executes
// RL13: with interrupts disabled, wake resumes at the instruction after sleep
module wimc_ctrl (
    ref_clk,
    sys_rst,
    mode,
    sleep_instr,
    global_int_enable_instr,
    global_int_disable_instr,
    ext_pin_wake_en,
    port_change_wake_en,
    comparator_wake_en,
    adc_done_wake_en,
    spi_slave_rx,
    adc_busy,
    src_event,
    wdt_timeout,
    low_voltage,
    wake_up,
    int_take,
    int_src,
    resume_next,
    int_enabled,
    device_reset,
    main_clock_keep,
    sub_clock_keep
);
    input  wire                     ref_clk;
    input  wire                     sys_rst;
    input  wire [`WIMC_MODE_W-1:0]  mode;
    input  wire                     sleep_instr;
    input  wire                     global_int_enable_instr;
    input  wire                     global_int_disable_instr;
    input  wire                     ext_pin_wake_en;
    input  wire                     port_change_wake_en;
    input  wire                     comparator_wake_en;
    input  wire                     adc_done_wake_en;
    input  wire                     spi_slave_rx;
    input  wire                     adc_busy;
    input  wire [`WIMC_SRC_W-1:0]   src_event;
    input  wire                     wdt_timeout;
    input  wire                     low_voltage;
    output reg                      wake_up;
    output reg                      int_take;
    output reg  [`WIMC_SRC_W-1:0]   int_src;
    output reg                      resume_next;
    output wire                     int_enabled;
    output reg                      device_reset;
    output reg                      main_clock_keep;
    output reg                      sub_clock_keep;

    reg                     gie_q;
    reg [3:0]               wen_q;
    reg [`WIMC_SRC_W-1:0]   wake_mask;
    wire                    low_power;

    // one place for the "any source pending" reduction used by the wake, interrupt and resume outcomes
    function any_set;
        input [`WIMC_SRC_W-1:0] v;
        begin
            any_set = |v;
        end
    endfunction

    assign int_enabled = gie_q;
    assign low_power = (mode == `WIMC_MODE_SLEEP) || (mode == `WIMC_MODE_IDLE);

    // global interrupt enable, driven by the enable/disable instructions
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            gie_q <= 1'b0;
        end else if (global_int_enable_instr) begin
            gie_q <= 1'b1;
        end else if (global_int_disable_instr) begin
            gie_q <= 1'b0;
        end
    end

    // enables sampled at the sleep instruction; later writes do not count until next sleep
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wen_q <= 4'h0;
        end else if (sleep_instr) begin
            wen_q <= {adc_done_wake_en, comparator_wake_en,
                      port_change_wake_en, ext_pin_wake_en}; // RL12
        end
    end

    // which sources may wake in the current low-power mode
    always @* begin
        wake_mask = `WIMC_SRC_NONE;
        case (mode)
            `WIMC_MODE_SLEEP, `WIMC_MODE_IDLE: begin
                wake_mask[`WIMC_SRC_EXT]  = wen_q[0]; // RL1
                wake_mask[`WIMC_SRC_PORT] = wen_q[1]; // RL2
                wake_mask[`WIMC_SRC_CMP]  = wen_q[2]; // RL3
                wake_mask[`WIMC_SRC_ADC]  = wen_q[3]; // RL4
                wake_mask[`WIMC_SRC_SPI]  = spi_slave_rx; // RL7
                if (mode == `WIMC_MODE_IDLE) begin
                    wake_mask[`WIMC_SRC_MTMR] = 1'b1; // RL6
                    wake_mask[`WIMC_SRC_T1]   = 1'b1; // RL6
                    wake_mask[`WIMC_SRC_T2]   = 1'b1; // RL6
                    wake_mask[`WIMC_SRC_T3]   = 1'b1; // RL6
                    wake_mask[`WIMC_SRC_PWM]  = 1'b1; // RL6
                end
                // uart sources stay masked here
                wake_mask[`WIMC_SRC_UTX] = 1'b0; // RL8
                wake_mask[`WIMC_SRC_URX] = 1'b0; // RL9
            end
            default: wake_mask = `WIMC_SRC_NONE;
        endcase
    end

    // outcome registered so the core sees clean one-cycle pulses
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wake_up         <= 1'b0;
            int_take        <= 1'b0;
            int_src         <= `WIMC_SRC_NONE;
            resume_next     <= 1'b0;
            device_reset    <= 1'b0;
            main_clock_keep <= 1'b0;
            sub_clock_keep  <= 1'b0;
        end else begin
            device_reset    <= wdt_timeout | low_voltage; // RL11
            main_clock_keep <= adc_busy & (mode != `WIMC_MODE_NORMAL); // RL5
            sub_clock_keep  <= adc_busy & (mode != `WIMC_MODE_NORMAL); // RL5
            if (wdt_timeout | low_voltage) begin
                // reset wins over any wake or interrupt in the same cycle
                wake_up     <= 1'b0;
                int_take    <= 1'b0;
                int_src     <= `WIMC_SRC_NONE;
                resume_next <= 1'b0;
            end else if (low_power) begin
                wake_up     <= any_set(src_event & wake_mask);
                int_take    <= gie_q & any_set(src_event & wake_mask);
                int_src     <= gie_q ? (src_event & wake_mask) : `WIMC_SRC_NONE;
                resume_next <= ~gie_q & any_set(src_event & wake_mask); // RL13
            end else begin
                wake_up     <= 1'b0;
                int_take    <= gie_q & any_set(src_event); // RL10
                int_src     <= gie_q ? src_event : `WIMC_SRC_NONE; // RL10
                resume_next <= ~gie_q & any_set(src_event); // RL10
            end
        end
    end
endmodule // wimc_ctrl

// File: test/tb_top.sv
// self-checking bench for the wake and interrupt control block
`timescale 1ns/1ps
module tb_top;
    reg         ref_clk = 0, sys_rst = 1, slp = 0, g_on = 0, g_off = 0, spi = 0, busy = 0;
    reg         wdt = 0, lv = 0;
    reg  [1:0]  mode = 0;
    reg  [3:0]  en = 0;
    wire [11:0] ev, isrc;
    wire        wk, it, rn, ie, dr, mk, sk;
    integer     n_mismatch = 0, num_checks = 0, i;
    always #2 ref_clk = ~ref_clk;
    wimc_src_model i_src (.ref_clk(ref_clk), .src_event(ev));
    wimc_ctrl i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mode(mode), .sleep_instr(slp),
        .global_int_enable_instr(g_on), .global_int_disable_instr(g_off),
        .ext_pin_wake_en(en[0]), .port_change_wake_en(en[1]), .comparator_wake_en(en[2]),
        .adc_done_wake_en(en[3]), .spi_slave_rx(spi), .adc_busy(busy), .src_event(ev),
        .wdt_timeout(wdt), .low_voltage(lv), .wake_up(wk), .int_take(it), .int_src(isrc),
        .resume_next(rn), .int_enabled(ie), .device_reset(dr), .main_clock_keep(mk),
        .sub_clock_keep(sk));
    task step; begin @(posedge ref_clk); #1; end endtask
    task chk(input [47:0] nm, input [11:0] seen, exp); begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin n_mismatch = n_mismatch + 1;
            $display("mismatch %0s exp %h seen %h", nm, exp, seen); end end endtask
    task stop_test; begin $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish; end endtask
    // enables are a snapshot, so clearing them after the pulse must not matter
    task latch(input [3:0] e); begin en = e; slp = 1; step; slp = 0; en = 0; end endtask
    task gie(input e); begin g_on = e; g_off = !e; step; g_on = 0; g_off = 0; end endtask
    task evt(input [1:0] m, input [11:0] s, input w, t, r); begin mode = m; i_src.fire(s);
        chk("wake", wk, w); chk("int", it, t); chk("src", isrc, t ? s : 0); chk("resume", rn, r);
    end endtask
    initial begin
        repeat (10) step;
        sys_rst = 0;
        step;
        gie(1);
        chk("gie", ie, 1);
        evt(1, 12'h3e0, 1, 1, 0);
        evt(0, 12'h3e0, 0, 0, 0);
        for (i = 0; i < 4; i = i + 1) begin
            latch(4'h0);
            evt(0, 12'h1 << i, 0, 0, 0);
            latch(4'h1 << i);
            evt(i[1:0] & 2'h1, 12'h1 << i, 1, 1, 0);
        end
        evt(0, 12'h010, 0, 0, 0);
        spi = 1;
        evt(0, 12'h010, 1, 1, 0);
        evt(1, 12'hc00, 0, 0, 0);
        for (i = 0; i < 12; i = i + 1) evt(2'h2 | (i[1:0] & 2'h1), 12'h1 << i, 0, 1, 0);
        gie(0);
        evt(2, 12'h400, 0, 0, 1);
        latch(4'h1);
        evt(0, 12'h001, 1, 0, 1);
        for (i = 0; i < 8; i = i + 1) begin
            mode = i[1:0];
            {lv, wdt} = i[2] ? 2'h2 : 2'h1;
            step;
            {lv, wdt} = 2'h0;
            chk("reset", dr, 1);
        end
        busy = 1; mode = 2;
        step;
        chk("keep", {mk, sk}, 3);
        stop_test;
    end
    initial begin #4000; n_mismatch = n_mismatch + 1; stop_test; end
endmodule // tb_top

// File: test/wimc_assertions.sv
// checker for the wake and interrupt control ports
`timescale 1ns/1ps
module wimc_assertions (
    input wire        ref_clk, sys_rst, adc_busy, wdt_timeout, low_voltage, wake_up,
    input wire        int_take, resume_next, int_enabled, device_reset,
    input wire        main_clock_keep, sub_clock_keep,
    input wire [1:0]  mode,
    input wire [11:0] src_event, int_src
);
    wire ok = !wdt_timeout && !low_voltage && |src_event;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_any_reset: assert property (wdt_timeout || low_voltage |=> device_reset)
        else $error("no reset");
    a_keep_clocks: assert property (adc_busy && mode != 2'h3 |=> main_clock_keep && sub_clock_keep)
        else $error("clocks stopped");
    a_uart_no_wake: assert property (!mode[1] && src_event[9:0] == 0 && ok |=> !wake_up && !int_take)
        else $error("uart woke");
    a_sleep_timer: assert property (mode == 2'h0 && src_event[4:0] == 0 |=> !wake_up)
        else $error("timer woke sleep");
    a_idle_timer: assert property (mode == 2'h1 && src_event[9:5] != 0 && ok |=> wake_up)
        else $error("timer missed idle");
    a_green_vector: assert property (mode[1] && int_enabled && ok |=> int_take && int_src == $past(src_event))
        else $error("no vector");
    a_green_quiet: assert property (mode[1] |=> !wake_up)
        else $error("wake when running");
    a_green_resume: assert property (mode[1] && !int_enabled && ok |=> resume_next && !int_take)
        else $error("no resume");
    cover property (wake_up && int_take);
    cover property (resume_next);
    cover property (main_clock_keep);
endmodule // wimc_assertions
bind wimc_ctrl wimc_assertions i_chk (.*);

// File: test/wimc_src_model.sv
// peripheral event sources feeding the block
`timescale 1ns/1ps
module wimc_src_model (
    input  wire        ref_clk,
    output reg  [11:0] src_event
);
    initial src_event = 12'h000;
    // one-cycle pulses only: a held level would read as a second event
    task fire(input [11:0] m);
        begin
            @(posedge ref_clk) #1 src_event = m;
            @(posedge ref_clk) #1 src_event = 12'h000;
        end
    endtask
endmodule // wimc_src_model
